// ---- hw/fcp_pkg.sv ----
// package: register map, field layout, codes and carrier types of the flash parameter block
package fcp_pkg;

  // register offsets as seen on the register port
  localparam logic [23:0] OFS_RD_BUF_LO   = 24'h7fc0c2;
  localparam logic [23:0] OFS_RD_BUF_HI   = 24'h7fc0c4;
  localparam logic [23:0] OFS_START_LO    = 24'h7fff82;
  localparam logic [23:0] OFS_START_HI    = 24'h7fff84;
  localparam logic [23:0] OFS_END_LO      = 24'h7fff86;
  localparam logic [23:0] OFS_END_HI      = 24'h7fff88;
  localparam logic [23:0] OFS_ERR_STATUS  = 24'h7fff8a;
  localparam logic [23:0] OFS_WR_BUF_LO   = 24'h7fff8c;
  localparam logic [23:0] OFS_WR_BUF_HI   = 24'h7fff8e;

  // reset values
  localparam logic [15:0] RST_HALF        = 16'h0000;
  localparam logic [3:0]  RST_NIBBLE      = 4'h0;
  localparam logic [19:0] RST_ADDR        = 20'h00000;
  localparam logic [7:0]  RST_STATUS      = 8'h00;

  // step of the unique-ID fetch address
  localparam logic [19:0] UID_STEP        = 20'h00004;

  // error status bit positions
  localparam int unsigned BIT_ERASE_ERR   = 0;
  localparam int unsigned BIT_PROG_ERR    = 1;
  localparam int unsigned BIT_BLANK_ERR   = 3;
  localparam int unsigned BIT_ILLEGAL     = 4;
  localparam int unsigned BIT_EXTRA_ILL   = 5;

  // main command codes
  localparam logic [3:0]  CMD_PROGRAM     = 4'h1;
  localparam logic [3:0]  CMD_BLANK_CHECK = 4'h3;
  localparam logic [3:0]  CMD_BLOCK_ERASE = 4'h4;
  localparam logic [3:0]  CMD_UID_READ    = 4'h5;

  // result events reported by the sequencer, one-cycle pulses
  typedef struct packed {
    logic erase_err;
    logic prog_err;
    logic blank_err;
    logic window_err;
  } fcp_seq_evt_t;

  // unique-ID word returned by the flash array
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } fcp_uid_rsp_t;

endpackage

// ---- hw/fcp_err_flags.sv ----
// error flag unit: the sticky result flags of the first status register
`timescale 1ns/1ps
module fcp_err_flags
  import fcp_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // command starts and their context
  input  wire logic         cmd_start,
  input  wire logic         extra_cmd_start,
  input  wire logic [3:0]   cmd_code,
  input  wire logic         extra_area_select_bit,
  input  wire logic         start_gt_end,
  // sequencer results
  input  wire fcp_seq_evt_t seq_evt,
  // flags
  output logic [7:0]        error_status
);

  logic erase_ff;
  logic prog_ff;
  logic blank_ff;
  logic ill_ff;
  logic xill_ff;

  // command class decode at start
  wire start_any  = cmd_start | extra_cmd_start;
  wire is_prog    = (cmd_code == CMD_PROGRAM);
  wire is_erase   = (cmd_code == CMD_BLOCK_ERASE);
  wire is_blank   = (cmd_code == CMD_BLANK_CHECK);
  wire is_uid     = (cmd_code == CMD_UID_READ);
  wire bad_code   = ~(is_prog | is_erase | is_blank | is_uid);
  wire ill_xsel   = (is_prog | is_erase) & extra_area_select_bit;
  wire ill_order  = (is_blank | is_erase) & start_gt_end;
  wire ill_start  = cmd_start & (bad_code | ill_xsel | ill_order);
  wire ill_set    = ill_start | seq_evt.window_err;
  wire xill_set   = extra_cmd_start & ~extra_area_select_bit;

  // sticky flags: a set in the start cycle wins over the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      erase_ff <= 1'b0;
      prog_ff  <= 1'b0;
      blank_ff <= 1'b0;
      ill_ff   <= 1'b0;
      xill_ff  <= 1'b0;
    end else begin
      erase_ff <= seq_evt.erase_err | (erase_ff & ~start_any);
      prog_ff  <= seq_evt.prog_err | (prog_ff & ~start_any);
      blank_ff <= seq_evt.blank_err | (blank_ff & ~start_any);
      ill_ff   <= ill_set | (ill_ff & ~start_any);
      xill_ff  <= xill_set | (xill_ff & ~start_any);
    end
  end

  // status byte, reserved bits read as zero
  always_comb begin
    error_status                = RST_STATUS;
    error_status[BIT_ERASE_ERR] = erase_ff;
    error_status[BIT_PROG_ERR]  = prog_ff;
    error_status[BIT_BLANK_ERR] = blank_ff;
    error_status[BIT_ILLEGAL]   = ill_ff;
    error_status[BIT_EXTRA_ILL] = xill_ff;
  end

  // checks on the flag behaviour
  property p_clear_on_start;
    @(posedge clock) disable iff (!rst_n)
      (start_any && !ill_set && !xill_set && !seq_evt.erase_err) |=>
        !error_status[BIT_EXTRA_ILL] && !error_status[BIT_ILLEGAL] && !erase_ff;
  endproperty
  a_clear_on_start: assert property (p_clear_on_start)
    else $error("error flag survived a command start");

  property p_erase_set;
    @(posedge clock) disable iff (!rst_n)
      seq_evt.erase_err |=> error_status[BIT_ERASE_ERR];
  endproperty
  a_erase_set: assert property (p_erase_set)
    else $error("erase error not flagged");

  property p_xsel_illegal;
    @(posedge clock) disable iff (!rst_n)
      (cmd_start && is_prog && extra_area_select_bit) |=> error_status[BIT_ILLEGAL];
  endproperty
  a_xsel_illegal: assert property (p_xsel_illegal)
    else $error("program with extra select not flagged illegal");

  property p_extra_illegal;
    @(posedge clock) disable iff (!rst_n)
      (extra_cmd_start && !extra_area_select_bit) |=> error_status[BIT_EXTRA_ILL];
  endproperty
  a_extra_illegal: assert property (p_extra_illegal)
    else $error("extra command without extra select not flagged");

  c_order_illegal: cover property (@(posedge clock) disable iff (!rst_n)
    cmd_start && is_erase && start_gt_end);

endmodule

// ---- hw/fcp_param_regs.sv ----
// flash parameter block: address, write buffer, read buffer and error status registers
// What this block does
// - start address holds bits 19..16 in high register, 15..0 in low
// - end address holds bits 19..16 in high register, 15..0 in low
// - address and write buffers accept writes only in ROM program/erase mode
// - flash reset bit clears them and blocks writes while it is one
// - during extra-area commands address and write buffer reads are not defined
// - unique-ID word splits: upper half to high buffer, lower to low
// - program word is high write buffer over low write buffer
// - high write buffer read is not defined during any command
// - erase error sets status bit 0, normal erase leaves it clear
// - program error sets status bit 1, normal program leaves it clear
// - blank-check error sets status bit 3, normal check leaves it clear
// - all error flags clear when the next command starts
// - forced stop during erase or blank check leaves flag undefined
// - program or erase outside the access window sets bit 4
// - blank check or erase with start above end sets bit 4
// - program or erase with extra select set sets bit 4
// - extra command with extra select clear sets bit 5
// - reserved status bits 2, 6, 7 carry no defined value
// - repeated unique-ID read with completion bit clear steps address by four
// - codes: program 1, blank check 3, erase 4, unique ID 5
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module fcp_param_regs
  import fcp_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // register port
  input  wire logic [23:0]  reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [15:0]       reg_rdata,
  // mode and control bits from the command logic
  input  wire logic         pe_mode,
  input  wire logic         flash_reset_bit,
  input  wire logic         extra_area_select_bit,
  input  wire logic [3:0]   cmd_code,
  input  wire logic         read_completion_bit,
  // command start and execution
  input  wire logic         cmd_start,
  input  wire logic         extra_cmd_start,
  input  wire logic         cmd_busy,
  input  wire logic         extra_cmd_busy,
  // sequencer and flash array results
  input  wire fcp_seq_evt_t seq_evt,
  input  wire fcp_uid_rsp_t uid_rsp,
  // parameters toward the sequencer
  output logic [19:0]       start_addr,
  output logic [19:0]       end_addr,
  output logic [31:0]       prog_data,
  // unique-ID fetch
  output logic              uid_fetch_req,
  output logic [19:0]       uid_fetch_addr,
  output logic              uid_data_ready,
  // status
  output logic [7:0]        error_status
);

  // unique-ID read sequencing states
  typedef enum logic [1:0] {
    UID_CLOSED,
    UID_FETCH,
    UID_READY
  } fcp_uid_state_t;

  // address match for the register port
  function automatic logic fcp_hit(input logic [23:0] addr, input logic [23:0] ofs);
    fcp_hit = (addr == ofs);
  endfunction

  // stored registers
  logic [3:0]     sa_hi_ff;
  logic [15:0]    sa_lo_ff;
  logic [3:0]     ea_hi_ff;
  logic [15:0]    ea_lo_ff;
  logic [15:0]    wb_hi_ff;
  logic [15:0]    wb_lo_ff;
  logic [15:0]    rb_hi_ff;
  logic [15:0]    rb_lo_ff;
  logic [15:0]    rdata_ff;
  logic [19:0]    fetch_addr_ff;
  fcp_uid_state_t uid_ff;

  // next values
  logic [19:0]    nxt_fetch_addr;
  fcp_uid_state_t nxt_uid;
  logic [15:0]    nxt_rdata;

  // write qualification
  wire wr_ok      = reg_wr & pe_mode & ~flash_reset_bit;
  wire clr_par    = ~rst_n | flash_reset_bit;
  wire wr_sa_hi   = wr_ok & fcp_hit(reg_addr, OFS_START_HI);
  wire wr_sa_lo   = wr_ok & fcp_hit(reg_addr, OFS_START_LO);
  wire wr_ea_hi   = wr_ok & fcp_hit(reg_addr, OFS_END_HI);
  wire wr_ea_lo   = wr_ok & fcp_hit(reg_addr, OFS_END_LO);
  wire wr_wb_hi   = wr_ok & fcp_hit(reg_addr, OFS_WR_BUF_HI);
  wire wr_wb_lo   = wr_ok & fcp_hit(reg_addr, OFS_WR_BUF_LO);

  // read hiding while commands run
  wire hide_par   = extra_cmd_busy;
  wire hide_wb_hi = cmd_busy | extra_cmd_busy;

  // unique-ID command decode
  wire uid_issue  = cmd_start & (cmd_code == CMD_UID_READ);
  wire uid_next   = uid_issue & ~read_completion_bit;
  wire uid_end    = uid_issue & read_completion_bit;

  // assembled parameter words
  assign start_addr = {sa_hi_ff, sa_lo_ff};
  assign end_addr   = {ea_hi_ff, ea_lo_ff};
  assign prog_data  = {wb_hi_ff, wb_lo_ff};
  wire   start_gt_end = (start_addr > end_addr);

  // start address pair
  always_ff @(posedge clock) begin
    if (clr_par) begin
      sa_hi_ff <= RST_NIBBLE;
      sa_lo_ff <= RST_HALF;
    end else begin
      if (wr_sa_hi) begin
        sa_hi_ff <= reg_wdata[3:0];
      end
      if (wr_sa_lo) begin
        sa_lo_ff <= reg_wdata;
      end
    end
  end

  // end address pair
  always_ff @(posedge clock) begin
    if (clr_par) begin
      ea_hi_ff <= RST_NIBBLE;
      ea_lo_ff <= RST_HALF;
    end else begin
      if (wr_ea_hi) begin
        ea_hi_ff <= reg_wdata[3:0];
      end
      if (wr_ea_lo) begin
        ea_lo_ff <= reg_wdata;
      end
    end
  end

  // program data write buffers
  always_ff @(posedge clock) begin
    if (clr_par) begin
      wb_hi_ff <= RST_HALF;
      wb_lo_ff <= RST_HALF;
    end else begin
      if (wr_wb_hi) begin
        wb_hi_ff <= reg_wdata;
      end
      if (wr_wb_lo) begin
        wb_lo_ff <= reg_wdata;
      end
    end
  end

  // unique-ID sequencing: first fetch from the start address, then step by four
  always_comb begin
    nxt_uid        = uid_ff;
    nxt_fetch_addr = fetch_addr_ff;
    case (uid_ff)
      UID_CLOSED: begin
        if (uid_next) begin
          nxt_fetch_addr = start_addr;
          nxt_uid        = UID_FETCH;
        end
      end
      UID_FETCH: begin
        if (uid_rsp.valid) begin
          nxt_uid = UID_READY;
        end
      end
      UID_READY: begin
        if (uid_end) begin
          nxt_uid = UID_CLOSED;
        end else if (uid_next) begin
          nxt_fetch_addr = fetch_addr_ff + UID_STEP;
          nxt_uid        = UID_FETCH;
        end
      end
      default: begin
        nxt_uid = UID_CLOSED;
      end
    endcase
  end

  // unique-ID state and fetch address
  always_ff @(posedge clock) begin
    if (clr_par) begin
      uid_ff        <= UID_CLOSED;
      fetch_addr_ff <= RST_ADDR;
    end else begin
      uid_ff        <= nxt_uid;
      fetch_addr_ff <= nxt_fetch_addr;
    end
  end

  // read buffers take the fetched word, split in halves
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rb_hi_ff <= RST_HALF;
      rb_lo_ff <= RST_HALF;
    end else if (uid_ff == UID_FETCH && uid_rsp.valid) begin  // no bus write path
      rb_hi_ff <= uid_rsp.word[31:16];
      rb_lo_ff <= uid_rsp.word[15:0];
    end
  end

  // fetch handshake toward the flash array
  assign uid_fetch_req  = (uid_ff == UID_FETCH);
  assign uid_fetch_addr = fetch_addr_ff;
  assign uid_data_ready = (uid_ff == UID_READY);

  // error flags
  fcp_err_flags u_err (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .cmd_start             (cmd_start),
    .extra_cmd_start       (extra_cmd_start),
    .cmd_code              (cmd_code),
    .extra_area_select_bit (extra_area_select_bit),
    .start_gt_end          (start_gt_end),
    .seq_evt               (seq_evt),
    .error_status          (error_status)
  );

  // read multiplexer: hidden or unmapped reads return zero
  always_comb begin
    nxt_rdata = RST_HALF;
    if (fcp_hit(reg_addr, OFS_START_HI) && !hide_par) begin
      nxt_rdata = {12'h000, sa_hi_ff};
    end else if (fcp_hit(reg_addr, OFS_START_LO) && !hide_par) begin
      nxt_rdata = sa_lo_ff;
    end else if (fcp_hit(reg_addr, OFS_END_HI) && !hide_par) begin
      nxt_rdata = {12'h000, ea_hi_ff};
    end else if (fcp_hit(reg_addr, OFS_END_LO) && !hide_par) begin
      nxt_rdata = ea_lo_ff;
    end else if (fcp_hit(reg_addr, OFS_WR_BUF_HI) && !hide_wb_hi) begin
      nxt_rdata = wb_hi_ff;
    end else if (fcp_hit(reg_addr, OFS_WR_BUF_LO) && !hide_par) begin
      nxt_rdata = wb_lo_ff;
    end else if (fcp_hit(reg_addr, OFS_RD_BUF_HI)) begin
      nxt_rdata = rb_hi_ff;
    end else if (fcp_hit(reg_addr, OFS_RD_BUF_LO)) begin
      nxt_rdata = rb_lo_ff;
    end else if (fcp_hit(reg_addr, OFS_ERR_STATUS)) begin
      nxt_rdata = {8'h00, error_status};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= RST_HALF;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : RST_HALF;
    end
  end

  assign reg_rdata = rdata_ff;

  // checks on the register behaviour
  wire [55:0] par_vec = {start_addr, end_addr[15:0], prog_data[19:0]};

  property p_wr_ignored;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && !pe_mode && !flash_reset_bit) |=> $stable({start_addr, end_addr, prog_data});
  endproperty
  a_wr_ignored: assert property (p_wr_ignored)
    else $error("write outside program/erase mode changed a register");

  property p_flash_reset_clears;
    @(posedge clock) disable iff (!rst_n)
      flash_reset_bit |=> (par_vec == 56'h0) && (end_addr[19:16] == RST_NIBBLE)
                          && (prog_data[31:20] == 12'h000);
  endproperty
  a_flash_reset_clears: assert property (p_flash_reset_clears)
    else $error("flash reset did not clear the parameters");

  property p_start_split;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && pe_mode && !flash_reset_bit && reg_addr == OFS_START_HI)
        |=> start_addr[19:16] == $past(reg_wdata[3:0]);
  endproperty
  a_start_split: assert property (p_start_split)
    else $error("start address high bits not taken");

  property p_end_split;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && pe_mode && !flash_reset_bit && reg_addr == OFS_END_LO)
        |=> end_addr[15:0] == $past(reg_wdata);
  endproperty
  a_end_split: assert property (p_end_split)
    else $error("end address low bits not taken");

  property p_prog_hi;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && pe_mode && !flash_reset_bit && reg_addr == OFS_WR_BUF_HI)
        |=> prog_data[31:16] == $past(reg_wdata);
  endproperty
  a_prog_hi: assert property (p_prog_hi)
    else $error("program word upper half wrong");

  property p_uid_split;
    @(posedge clock) disable iff (!rst_n || flash_reset_bit)
      (uid_fetch_req && uid_rsp.valid) |=> uid_data_ready
        && rb_hi_ff == $past(uid_rsp.word[31:16]) && rb_lo_ff == $past(uid_rsp.word[15:0]);
  endproperty
  a_uid_split: assert property (p_uid_split)
    else $error("unique-ID word not split into read buffers");

  property p_uid_step;
    @(posedge clock) disable iff (!rst_n || flash_reset_bit)
      (uid_data_ready && uid_next) |=> uid_fetch_req
        && uid_fetch_addr == $past(uid_fetch_addr) + UID_STEP;
  endproperty
  a_uid_step: assert property (p_uid_step)
    else $error("unique-ID address did not step by four");

  property p_ro_buffers;
    @(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == OFS_RD_BUF_HI && !uid_fetch_req) |=> $stable(rb_hi_ff);
  endproperty
  a_ro_buffers: assert property (p_ro_buffers)
    else $error("write changed a read-only buffer");

  property p_rd_idle;
    @(posedge clock) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");

  property p_wb_hi_hidden;
    @(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == OFS_WR_BUF_HI && cmd_busy) |=> reg_rdata == RST_HALF;
  endproperty
  a_wb_hi_hidden: assert property (p_wb_hi_hidden)
    else $error("write buffer high readable during a command");

  // main scenarios
  c_uid_two_words: cover property (@(posedge clock) disable iff (!rst_n)
    uid_data_ready && uid_next ##[1:20] uid_data_ready);
  c_hidden_read: cover property (@(posedge clock) disable iff (!rst_n)
    reg_rd && extra_cmd_busy && reg_addr == OFS_START_LO);
  c_prog_param: cover property (@(posedge clock) disable iff (!rst_n)
    wr_wb_hi ##[1:4] wr_wb_lo ##[1:4] cmd_start);

endmodule

// ---- testbench/fcp_flash_model.sv ----
// flash array model: answers unique-ID fetch requests after a chosen delay
`timescale 1ns/1ps
module fcp_flash_model
  import fcp_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // fetch request from the block
  input  wire logic         uid_fetch_req,
  input  wire logic [19:0]  uid_fetch_addr,
  // answer delay in cycles, chosen by the bench
  input  wire logic [3:0]   resp_delay,
  // fetched word toward the block
  output fcp_uid_rsp_t      uid_rsp
);
  logic [3:0] wait_ff;
  logic       done_ff;

  // one answer per request; the word lines toggle when no answer is presented
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
      uid_rsp <= '0;
    end else begin
      uid_rsp.valid <= 1'b0;
      uid_rsp.word  <= ~uid_rsp.word;
      if (!uid_fetch_req) begin
        wait_ff <= 4'h0;
        done_ff <= 1'b0;
      end else if (!done_ff) begin
        if (wait_ff == resp_delay) begin
          uid_rsp.valid <= 1'b1;
          uid_rsp.word  <= {4'ha, uid_fetch_addr, 8'h5c}; // address-tagged word
          done_ff       <= 1'b1;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule

// ---- testbench/fcp_param_regs_bench.sv ----
// testbench: register access, error flags and unique-ID fetch of the parameter block
`timescale 1ns/1ps
module fcp_param_regs_bench
  import fcp_pkg::*;
;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic [23:0]  reg_addr = '0;
  logic [15:0]  reg_wdata = '0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic         pe_mode = 1'b1;
  logic         flash_reset_bit = 1'b0;
  logic         extra_area_select_bit = 1'b0;
  logic [3:0]   cmd_code = 4'h0;
  logic         read_completion_bit = 1'b0;
  logic         cmd_start = 1'b0;
  logic         extra_cmd_start = 1'b0;
  logic         cmd_busy = 1'b0;
  logic         extra_cmd_busy = 1'b0;
  fcp_seq_evt_t seq_evt = '0;
  logic [3:0]   resp_delay = 4'h2;
  fcp_uid_rsp_t uid_rsp;
  logic [15:0]  reg_rdata;
  logic [19:0]  start_addr;
  logic [19:0]  end_addr;
  logic [31:0]  prog_data;
  logic         uid_fetch_req;
  logic [19:0]  uid_fetch_addr;
  logic         uid_data_ready;
  logic [7:0]   error_status;
  int           n_fail = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  logic [23:0]  ofs [9] = '{OFS_RD_BUF_LO, OFS_RD_BUF_HI, OFS_START_LO, OFS_START_HI,
                          OFS_END_LO, OFS_END_HI, OFS_ERR_STATUS, OFS_WR_BUF_LO, OFS_WR_BUF_HI};

  always #10 clock = ~clock;

  fcp_param_regs DUT (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pe_mode(pe_mode),
    .flash_reset_bit(flash_reset_bit), .extra_area_select_bit(extra_area_select_bit),
    .cmd_code(cmd_code), .read_completion_bit(read_completion_bit), .cmd_start(cmd_start),
    .extra_cmd_start(extra_cmd_start), .cmd_busy(cmd_busy), .extra_cmd_busy(extra_cmd_busy),
    .seq_evt(seq_evt), .uid_rsp(uid_rsp), .start_addr(start_addr), .end_addr(end_addr),
    .prog_data(prog_data), .uid_fetch_req(uid_fetch_req), .uid_fetch_addr(uid_fetch_addr),
    .uid_data_ready(uid_data_ready), .error_status(error_status));

  fcp_flash_model flash (
    .clock(clock), .rst_n(rst_n), .uid_fetch_req(uid_fetch_req),
    .uid_fetch_addr(uid_fetch_addr), .resp_delay(resp_delay), .uid_rsp(uid_rsp));

  // verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // register port write and read
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(e));
  endtask

  // one command start, main or extra area
  task automatic cmd(input logic [3:0] c, input logic rcb, input logic sel, input logic x);
    @(posedge clock);
    cmd_code              <= c;
    read_completion_bit   <= rcb;
    extra_area_select_bit <= sel;
    cmd_start             <= ~x;
    extra_cmd_start       <= x;
    @(posedge clock);
    cmd_start             <= 1'b0;
    extra_cmd_start       <= 1'b0;
    #1;
  endtask
  task automatic evt(input logic [3:0] e);
    @(posedge clock);
    seq_evt <= e;
    @(posedge clock);
    seq_evt <= '0;
    #1;
  endtask
  task automatic stat(input logic [7:0] e);
    chk(32'(error_status & 8'h3b), 32'(e));
  endtask

  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd(ofs[i], 16'h0000);
  endtask

  task automatic t_regs();
    wr(OFS_START_LO, 16'h1234);
    wr(OFS_START_HI, 16'hfff5);
    wr(OFS_END_LO, 16'h5678);
    wr(OFS_END_HI, 16'h0006);
    wr(OFS_WR_BUF_LO, 16'hbeef);
    wr(OFS_WR_BUF_HI, 16'hcafe);
    chk(32'(start_addr), 32'h51234);
    chk(32'(end_addr), 32'h65678);
    chk(prog_data, 32'hcafebeef);
    rd(OFS_START_HI, 16'h0005);
    rd(OFS_END_LO, 16'h5678);
  endtask

  task automatic t_refuse();
    @(posedge clock);
    pe_mode <= 1'b0;
    wr(OFS_START_LO, 16'h0000);
    chk(32'(start_addr), 32'h51234);
    @(posedge clock);
    pe_mode <= 1'b1;
    wr(OFS_ERR_STATUS, 16'h00ff);
    stat(8'h00);
    wr(24'h7fff90, 16'hffff);
    rd(24'h7fff90, 16'h0000);
    @(posedge clock);
    flash_reset_bit <= 1'b1;
    wr(OFS_START_LO, 16'h1110);
    chk({12'h000, start_addr}, 32'h0);
    chk(prog_data, 32'h0);
    @(posedge clock);
    flash_reset_bit <= 1'b0;
  endtask

  task automatic t_busy();
    wr(OFS_START_LO, 16'h0abc);
    wr(OFS_WR_BUF_LO, 16'h1357);
    wr(OFS_WR_BUF_HI, 16'h2468);
    @(posedge clock);
    extra_cmd_busy <= 1'b1;
    rd(OFS_START_LO, 16'h0000);
    rd(OFS_WR_BUF_LO, 16'h0000);
    @(posedge clock);
    extra_cmd_busy <= 1'b0;
    cmd_busy       <= 1'b1;
    rd(OFS_WR_BUF_HI, 16'h0000);
    rd(OFS_WR_BUF_LO, 16'h1357);
    @(posedge clock);
    cmd_busy       <= 1'b0;
    rd(OFS_WR_BUF_HI, 16'h2468);
  endtask

  task automatic t_flags();
    wr(OFS_END_LO, 16'h0ffc);
    evt(4'b1000);
    stat(8'h01);
    evt(4'b0001);
    stat(8'h11);
    cmd(CMD_PROGRAM, 1'b0, 1'b0, 1'b0);
    stat(8'h00);
    evt(4'b0100);
    stat(8'h02);
    cmd(CMD_BLANK_CHECK, 1'b0, 1'b0, 1'b0);
    stat(8'h00);
    evt(4'b0010);
    stat(8'h08);
    cmd(CMD_PROGRAM, 1'b0, 1'b1, 1'b0);
    stat(8'h10);
    cmd(CMD_BLOCK_ERASE, 1'b0, 1'b1, 1'b0);
    stat(8'h10);
    cmd(4'h0, 1'b0, 1'b1, 1'b1);
    stat(8'h00);
    cmd(4'h0, 1'b0, 1'b0, 1'b1);
    stat(8'h20);
    cmd(4'h2, 1'b0, 1'b0, 1'b0);
    stat(8'h10);
    wr(OFS_START_HI, 16'h000f);
    cmd(CMD_BLANK_CHECK, 1'b0, 1'b0, 1'b0);
    stat(8'h10);
    cmd(CMD_PROGRAM, 1'b0, 1'b0, 1'b0);
    stat(8'h00);
    cmd(CMD_BLOCK_ERASE, 1'b0, 1'b0, 1'b0);
    stat(8'h10);
  endtask

  // one unique-ID fetch and a check of both read buffers
  task automatic uid_step(input logic [19:0] a);
    logic [31:0] w;
    w = {4'ha, a, 8'h5c};
    cmd(CMD_UID_READ, 1'b0, 1'b1, 1'b0);
    chk({11'h000, uid_fetch_req, uid_fetch_addr}, {11'h000, 1'b1, a});
    for (int i = 0; i < 40 && uid_data_ready !== 1'b1; i++) @(posedge clock);
    #1 chk(32'(uid_data_ready), 32'h1);
    rd(OFS_RD_BUF_HI, w[31:16]);
    rd(OFS_RD_BUF_LO, w[15:0]);
  endtask

  task automatic t_uid();
    wr(OFS_START_HI, 16'h0000);
    wr(OFS_START_LO, 16'h0850);
    uid_step(20'h00850);
    stat(8'h00);
    @(posedge clock);
    resp_delay <= 4'h5;
    uid_step(20'h00854);
    wr(OFS_RD_BUF_HI, 16'h1111);
    rd(OFS_RD_BUF_HI, 16'ha008);
    cmd(CMD_UID_READ, 1'b1, 1'b1, 1'b0);
    chk(32'(uid_data_ready), 32'h0);
  endtask

  // cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_refuse();
    t_busy();
    t_flags();
    t_uid();
    tally_and_finish();
  end
endmodule
